// >>> inc/aacsr_pkg.sv
// constants for the audio amplifier control and status register bank
`default_nettype none
package aacsr_pkg;
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_CLK  = 3'h0; // detected clock status
	localparam logic [2:0] IDX_ID   = 3'h1; // identification
	localparam logic [2:0] IDX_ERR  = 3'h2; // sticky error flags
	localparam logic [2:0] IDX_SC1  = 3'h3; // system control one
	localparam logic [2:0] IDX_SFMT = 3'h4; // serial format select
	localparam logic [2:0] IDX_SC2  = 3'h5; // system control two
	localparam logic [2:0] IDX_MUTE = 3'h6; // channel soft mute
	localparam logic [2:0] IDX_LAST = 3'h6; // highest mapped index

	// reset values
	localparam logic [7:0] RST_CLK  = 8'h6C; // 44.1/48 kHz, 256x
	localparam logic [7:0] RST_ERR  = 8'h00;
	localparam logic [7:0] RST_SC1  = 8'hA0; // dc block on, hard unmute
	localparam logic [7:0] RST_SFMT = 8'h05; // 24-bit i2s
	localparam logic [7:0] RST_SC2  = 8'h40; // all channels shut down
	localparam logic [7:0] RST_MUTE = 8'h00;

	// writable bit masks, reserved bits read zero
	localparam logic [7:0] MSK_ERR  = 8'hFB;
	localparam logic [7:0] MSK_SC1  = 8'hA3;
	localparam logic [7:0] MSK_SFMT = 8'h0F;
	localparam logic [7:0] MSK_SC2  = 8'h40;
	localparam logic [7:0] MSK_MUTE = 8'h03;

	// field positions
	localparam int ERR_MCLK  = 7;
	localparam int ERR_PLL   = 6;
	localparam int ERR_SCLK  = 5;
	localparam int ERR_FRAME = 4;
	localparam int ERR_SLIP  = 3;
	localparam int ERR_FAULT = 1;
	localparam int ERR_OTW   = 0;
	localparam int SC1_DCB   = 7;
	localparam int SC1_HARD  = 5;
	localparam int SC2_SHDN  = 6;
	localparam int ST_RATE_LSB  = 5;
	localparam int ST_RATIO_LSB = 2;

	// sample rate codes
	localparam logic [2:0] SR_32K = 3'b000;
	localparam logic [2:0] SR_48K = 3'b011;
	localparam logic [2:0] SR_16K = 3'b100;
	localparam logic [2:0] SR_24K = 3'b101;
	localparam logic [2:0] SR_8K  = 3'b110;
	localparam logic [2:0] SR_12K = 3'b111;

	// master clock ratio codes
	localparam logic [2:0] MR_64  = 3'b000;
	localparam logic [2:0] MR_128 = 3'b001;
	localparam logic [2:0] MR_192 = 3'b010;
	localparam logic [2:0] MR_256 = 3'b011;
	localparam logic [2:0] MR_384 = 3'b100;
	localparam logic [2:0] MR_512 = 3'b101;

	// sample rate decision boundaries in hz
	localparam int FSB_8_12  = 9500;
	localparam int FSB_12_16 = 13800;
	localparam int FSB_16_24 = 19000;
	localparam int FSB_24_32 = 28000;
	localparam int FSB_32_48 = 38000;

	// master clocks per frame decision boundaries
	localparam logic [15:0] MRB_64_128  = 16'h0060;
	localparam logic [15:0] MRB_128_192 = 16'h00A0;
	localparam logic [15:0] MRB_192_256 = 16'h00E0;
	localparam logic [15:0] MRB_256_384 = 16'h0140;
	localparam logic [15:0] MRB_384_512 = 16'h01C0;

	// tolerated count jitter from sampling
	localparam logic [15:0] TOL_FRAME = 16'h0002;
	localparam logic [15:0] TOL_CLK   = 16'h0001;
	localparam logic [15:0] TOL_SLIP  = 16'h0004;

	// apb answer phase
	typedef enum logic [0:0] {
		AP_IDLE = 1'b0, // waiting for an access phase
		AP_DONE = 1'b1  // pready shown this cycle
	} aacsr_apb_t;
endpackage
`default_nettype wire

// >>> design/aacsr_top.sv
// control and status register bank with clock monitor, apb slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aacsr_top #(
	parameter int              PCLK_HZ = 100000000, // system clock rate
	parameter int              ADDR_W  = 8,         // apb address width
	parameter logic [6:0]      ID_CODE = 7'h15      // arbitrary value
) (
	input  wire logic              pclk,          // system clock
	input  wire logic              presetn,       // async reset, low active
	input  wire logic              psel,          // apb select
	input  wire logic              penable,       // apb enable
	input  wire logic              pwrite,        // apb direction
	input  wire logic [ADDR_W-1:0] paddr,         // apb byte address
	input  wire logic [31:0]       pwdata,        // apb write data
	output logic                   pready,        // apb ready
	output logic [31:0]            prdata,        // apb read data
	output logic                   pslverr,       // apb error
	input  wire logic              mclk_in,       // sampled master clock
	input  wire logic              sclk_in,       // sampled bit clock
	input  wire logic              lrclk_in,      // sampled frame clock
	input  wire logic              pll_fail,      // pll autolock failure
	input  wire logic              power_fault,   // current/temp/voltage fault
	input  wire logic              overtemp_warn, // overtemperature warning
	output logic                   dc_block_en,   // dc blocking filter enable
	output logic                   hard_unmute,   // single step unmute
	output logic [1:0]             deemph_sel,    // de-emphasis select
	output logic [3:0]             serial_format, // input format code
	output logic                   all_shutdown,  // all channel hard mute
	output aacsr_pkg::aacsr_apb_t  apb_phase,     // apb answer phase
	output logic [1:0]             soft_mute      // per channel soft mute
);
	import aacsr_pkg::*;

	// frame period thresholds in pclk cycles
	localparam logic [15:0] TH_8_12  = 16'(PCLK_HZ / FSB_8_12);
	localparam logic [15:0] TH_12_16 = 16'(PCLK_HZ / FSB_12_16);
	localparam logic [15:0] TH_16_24 = 16'(PCLK_HZ / FSB_16_24);
	localparam logic [15:0] TH_24_32 = 16'(PCLK_HZ / FSB_24_32);
	localparam logic [15:0] TH_32_48 = 16'(PCLK_HZ / FSB_32_48);

	// whole block state
	typedef struct packed {
		aacsr_apb_t  apb;       // apb phase
		logic        pready;    // ready flop
		logic [31:0] prdata;    // read data flop
		logic        pslverr;   // error flop
		logic [7:0]  clk_stat;  // detected rate and ratio
		logic [7:0]  err;       // sticky error flags
		logic [7:0]  sc1;       // system control one
		logic [7:0]  sfmt;      // serial format
		logic [7:0]  sc2;       // system control two
		logic [7:0]  mute;      // soft mute
		logic        mclk_d;    // previous mclk sample
		logic        sclk_d;    // previous sclk sample
		logic        lr_d;      // previous frame clock sample
		logic [1:0]  meas;      // frames seen, saturating at two
		logic [15:0] frm_cnt;   // pclk cycles in current frame
		logic [15:0] frm_prev;  // last frame period
		logic [9:0]  mclk_cnt;  // mclk edges in current frame
		logic [9:0]  mclk_prev; // last mclk count
		logic [8:0]  sclk_cnt;  // sclk edges in current frame
		logic [8:0]  sclk_prev; // last sclk count
		logic [15:0] int_cnt;   // internal frame sync phase
	} aacsr_state_t;

	aacsr_state_t st_r;   // registered state
	aacsr_state_t st_nxt; // next state

	// distance between two counts
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// word-aligned index hit
	function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [2:0] idx);
		idx_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction

	// sample rate code from frame period
	function automatic logic [2:0] rate_code(input logic [15:0] per);
		if (per > TH_8_12) begin
			rate_code = SR_8K;
		end else if (per > TH_12_16) begin
			rate_code = SR_12K;
		end else if (per > TH_16_24) begin
			rate_code = SR_16K;
		end else if (per > TH_24_32) begin
			rate_code = SR_24K;
		end else if (per > TH_32_48) begin
			rate_code = SR_32K;
		end else begin
			rate_code = SR_48K;
		end
	endfunction

	// ratio code from master clocks per frame
	function automatic logic [2:0] ratio_code(input logic [15:0] n);
		if (n < MRB_64_128) begin
			ratio_code = MR_64;
		end else if (n < MRB_128_192) begin
			ratio_code = MR_128;
		end else if (n < MRB_192_256) begin
			ratio_code = MR_192;
		end else if (n < MRB_256_384) begin
			ratio_code = MR_256;
		end else if (n < MRB_384_512) begin
			ratio_code = MR_384;
		end else begin
			ratio_code = MR_512;
		end
	endfunction

	// edge and event terms
	logic        mclk_rise;  // master clock rising edge
	logic        sclk_rise;  // bit clock rising edge
	logic        lr_rise;    // frame clock rising edge
	logic        cmp_ok;     // a full previous frame exists
	logic        mclk_chg;   // mclk per frame changed
	logic        sclk_chg;   // sclk per frame changed
	logic        frm_chg;    // frame period changed
	logic        slip;       // frame phase drifted
	logic        mapped;     // address hits a register
	logic        acc_take;   // access phase taken this cycle
	logic        wr_fire;    // write completes this edge
	logic [7:0]  set_vec;    // hardware error sets
	logic [7:0]  rd_byte;    // read multiplexer
	logic [15:0] near_end;   // frame period less slip margin

	// edges and change detection
	always_comb begin
		mclk_rise = mclk_in & ~st_r.mclk_d;
		sclk_rise = sclk_in & ~st_r.sclk_d;
		lr_rise   = lrclk_in & ~st_r.lr_d;
		cmp_ok    = lr_rise && (st_r.meas == 2'd2);
		near_end  = st_r.frm_prev - TOL_SLIP;
		mclk_chg  = cmp_ok && (absdiff({6'h00, st_r.mclk_cnt}, {6'h00, st_r.mclk_prev}) > TOL_CLK);
		sclk_chg  = cmp_ok && (absdiff({7'h00, st_r.sclk_cnt}, {7'h00, st_r.sclk_prev}) > TOL_CLK);
		frm_chg   = cmp_ok && (absdiff(st_r.frm_cnt, st_r.frm_prev) > TOL_FRAME);
		// internal sync should sit near its wrap at each incoming frame edge
		slip      = cmp_ok && (st_r.int_cnt > TOL_SLIP) && (st_r.int_cnt < near_end);
		set_vec   = 8'h00;
		set_vec[ERR_MCLK]  = mclk_chg;
		set_vec[ERR_SCLK]  = sclk_chg;
		set_vec[ERR_FRAME] = frm_chg;
		set_vec[ERR_SLIP]  = slip;
		set_vec[ERR_PLL]   = pll_fail;
		set_vec[ERR_FAULT] = power_fault;
		set_vec[ERR_OTW]   = overtemp_warn;
	end

	// apb decode and read multiplexer
	always_comb begin
		mapped   = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:2] <= (ADDR_W-2)'(IDX_LAST));
		acc_take = psel && penable && (st_r.apb == AP_IDLE);
		wr_fire  = psel && penable && pwrite && (st_r.apb == AP_DONE);
		rd_byte  = 8'h00;
		if (idx_hit(paddr, IDX_CLK)) begin
			rd_byte = st_r.clk_stat;
		end else if (idx_hit(paddr, IDX_ID)) begin
			rd_byte = {1'b0, ID_CODE};
		end else if (idx_hit(paddr, IDX_ERR)) begin
			rd_byte = st_r.err;
		end else if (idx_hit(paddr, IDX_SC1)) begin
			rd_byte = st_r.sc1;
		end else if (idx_hit(paddr, IDX_SFMT)) begin
			rd_byte = st_r.sfmt;
		end else if (idx_hit(paddr, IDX_SC2)) begin
			rd_byte = st_r.sc2;
		end else if (idx_hit(paddr, IDX_MUTE)) begin
			rd_byte = st_r.mute;
		end
	end

	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.mclk_d = mclk_in;
		st_nxt.sclk_d = sclk_in;
		st_nxt.lr_d   = lrclk_in;
		// apb answer one cycle after the access phase starts
		case (st_r.apb)
			AP_IDLE: begin
				st_nxt.pready = 1'b0;
				if (acc_take) begin
					st_nxt.apb     = AP_DONE;
					st_nxt.pready  = 1'b1;
					st_nxt.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
					st_nxt.pslverr = ~mapped;
				end
			end
			AP_DONE: begin
				st_nxt.apb     = AP_IDLE;
				st_nxt.pready  = 1'b0;
				st_nxt.pslverr = 1'b0;
			end
			default: begin
				st_nxt.apb    = AP_IDLE;
				st_nxt.pready = 1'b0;
			end
		endcase
		// register writes; status and id have no write path
		if (wr_fire) begin
			if (idx_hit(paddr, IDX_SC1)) begin
				st_nxt.sc1 = pwdata[7:0] & MSK_SC1;
			end
			if (idx_hit(paddr, IDX_SFMT)) begin
				st_nxt.sfmt = pwdata[7:0] & MSK_SFMT;
			end
			if (idx_hit(paddr, IDX_SC2)) begin
				st_nxt.sc2 = pwdata[7:0] & MSK_SC2;
			end
			if (idx_hit(paddr, IDX_MUTE)) begin
				st_nxt.mute = pwdata[7:0] & MSK_MUTE;
			end
		end
		// error flags: zero written clears, hardware set wins
		if (wr_fire && idx_hit(paddr, IDX_ERR)) begin
			st_nxt.err = (st_r.err & pwdata[7:0] & MSK_ERR) | set_vec;
		end else begin
			st_nxt.err = st_r.err | set_vec;
		end
		// per-frame counting of pclk, mclk and sclk
		if (lr_rise) begin
			st_nxt.frm_cnt  = 16'h0001;
			st_nxt.mclk_cnt = mclk_rise ? 10'h001 : 10'h000;
			st_nxt.sclk_cnt = sclk_rise ? 9'h001 : 9'h000;
			if (st_r.meas != 2'd0) begin
				// previous frame was complete, capture and classify it
				st_nxt.frm_prev  = st_r.frm_cnt;
				st_nxt.mclk_prev = st_r.mclk_cnt;
				st_nxt.sclk_prev = st_r.sclk_cnt;
				st_nxt.meas      = 2'd2;
				st_nxt.clk_stat  = {rate_code(st_r.frm_cnt), ratio_code({6'h00, st_r.mclk_cnt}), 2'b00};
			end else begin
				st_nxt.meas = 2'd1;
			end
			st_nxt.int_cnt = 16'h0000; // realign internal sync
		end else begin
			if (st_r.frm_cnt != 16'hFFFF) begin
				st_nxt.frm_cnt = st_r.frm_cnt + 16'h0001;
			end
			if (mclk_rise && (st_r.mclk_cnt != 10'h3FF)) begin
				st_nxt.mclk_cnt = st_r.mclk_cnt + 10'h001;
			end
			if (sclk_rise && (st_r.sclk_cnt != 9'h1FF)) begin
				st_nxt.sclk_cnt = st_r.sclk_cnt + 9'h001;
			end
			// internal frame sync free-runs at the last period
			if ((st_r.int_cnt + 16'h0001) >= st_r.frm_prev) begin
				st_nxt.int_cnt = 16'h0000;
			end else begin
				st_nxt.int_cnt = st_r.int_cnt + 16'h0001;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r           <= '0;
			st_r.apb       <= AP_IDLE;
			st_r.clk_stat  <= RST_CLK;
			st_r.err       <= RST_ERR;
			st_r.sc1       <= RST_SC1;
			st_r.sfmt      <= RST_SFMT;
			st_r.sc2       <= RST_SC2;
			st_r.mute      <= RST_MUTE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state flops
	assign pready        = st_r.pready;
	assign prdata        = st_r.prdata;
	assign pslverr       = st_r.pslverr;
	assign apb_phase     = st_r.apb;
	assign dc_block_en   = st_r.sc1[SC1_DCB];
	assign hard_unmute   = st_r.sc1[SC1_HARD];
	assign deemph_sel    = st_r.sc1[1:0];
	assign serial_format = st_r.sfmt[3:0];
	assign all_shutdown  = st_r.sc2[SC2_SHDN];
	assign soft_mute     = st_r.mute[1:0];

	// checks on the design's own behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_err_sticky;
		!(wr_fire && idx_hit(paddr, IDX_ERR)) |=> ((st_r.err & $past(st_r.err)) == $past(st_r.err));
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped without a clearing write");

	property p_mclk_err;
		mclk_chg |=> st_r.err[ERR_MCLK];
	endproperty
	a_mclk_err: assert property (p_mclk_err) else $error("mclk change did not set its flag");

	property p_sclk_err;
		sclk_chg |=> st_r.err[ERR_SCLK];
	endproperty
	a_sclk_err: assert property (p_sclk_err) else $error("sclk change did not set its flag");

	property p_frame_err;
		// a clearing write right after the set may legally drop the flag again
		frm_chg |=> st_r.err[ERR_FRAME] ##1
			(st_r.err[ERR_FRAME] || $past(wr_fire && idx_hit(paddr, IDX_ERR) && !pwdata[ERR_FRAME]));
	endproperty
	a_frame_err: assert property (p_frame_err) else $error("frame change flag missing or lost");

	property p_slip_err;
		slip |=> st_r.err[ERR_SLIP];
	endproperty
	a_slip_err: assert property (p_slip_err) else $error("frame slip did not set its flag");

	property p_fault_err;
		(pll_fail || power_fault || overtemp_warn) |=>
			(st_r.err[ERR_PLL] == $past(pll_fail) || st_r.err[ERR_PLL]) &&
			(st_r.err[ERR_FAULT] || !$past(power_fault)) && (st_r.err[ERR_OTW] || !$past(overtemp_warn));
	endproperty
	a_fault_err: assert property (p_fault_err) else $error("fault input did not set its flag");

	property p_id_read;
		(acc_take && !pwrite && idx_hit(paddr, IDX_ID)) |=> pready && (prdata == {25'h000_0000, ID_CODE});
	endproperty
	a_id_read: assert property (p_id_read) else $error("id read returned wrong value");

	property p_rate_code;
		(lr_rise && st_r.meas != 2'd0 && st_r.frm_cnt <= TH_32_48) |=> (st_r.clk_stat[7:5] == SR_48K);
	endproperty
	a_rate_code: assert property (p_rate_code) else $error("short frame not reported as 44.1/48 khz");

	property p_ratio_code;
		(lr_rise && st_r.meas != 2'd0 && st_r.mclk_cnt >= 10'(MRB_384_512)) |=>
			(st_r.clk_stat[4:2] == MR_512) && (st_r.clk_stat[1:0] == 2'b00);
	endproperty
	a_ratio_code: assert property (p_ratio_code) else $error("512x ratio not reported");

	property p_ro_write;
		(wr_fire && idx_hit(paddr, IDX_CLK) && !lr_rise) |=> $stable(st_r.clk_stat);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("write changed clock status");

	property p_shutdown;
		(wr_fire && idx_hit(paddr, IDX_SC2)) |=> (all_shutdown == $past(pwdata[SC2_SHDN]));
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown did not follow the write");

	property p_mute;
		// the master may change pwdata right after the answer edge, so look back to that edge
		(wr_fire && idx_hit(paddr, IDX_MUTE)) |=>
			(soft_mute == $past(pwdata[1:0])) ##1 (soft_mute == $past(pwdata[1:0], 2));
	endproperty
	a_mute: assert property (p_mute) else $error("soft mute did not follow the write");

	property p_answer;
		acc_take |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer) else $error("apb answer not exactly one cycle");

endmodule
`default_nettype wire

// >>> bench/aacsr_clk_src.sv
// serial audio clock source model: master, bit and frame clocks
`timescale 1ns/1ps
`default_nettype none
module aacsr_clk_src (
	input  wire logic        pclk,    // system clock
	input  wire logic        presetn, // async reset, low active
	input  wire logic [15:0] half_mc, // master clock half period in pclk cycles
	input  wire logic [15:0] ratio,   // master clocks per frame
	input  wire logic [15:0] bits,    // bit clocks per frame
	input  wire logic        jump,    // restart the frame mid-way
	output logic             mclk,    // master clock
	output logic             sclk,    // bit clock
	output logic             lrclk    // frame clock, high in the first half
);
	logic [15:0] cnt_r; // position inside the frame
	logic [15:0] per_r; // active frame length
	logic [15:0] hm_r;  // active master half period
	logic [15:0] bp_r;  // active bit clock period
	logic [15:0] per_n; // frame length asked for
	assign per_n = 16'(2 * ratio * half_mc);
	// new settings only load at a frame boundary so no frame mixes two settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			per_r <= per_n;
			hm_r  <= half_mc;
			bp_r  <= per_n / bits;
		end else if (jump) begin
			cnt_r <= 16'h0000; // phase jump, only when the bench asks
		end else if (cnt_r >= per_r - 16'h0001) begin
			cnt_r <= 16'h0000;
			per_r <= per_n;
			hm_r  <= half_mc;
			bp_r  <= per_n / bits;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	// clocks are whole divisions of the frame position
	assign mclk  = (cnt_r % (hm_r << 1)) < hm_r;
	assign sclk  = (cnt_r % bp_r) < (bp_r >> 1);
	assign lrclk = cnt_r < (per_r >> 1);
endmodule
`default_nettype wire

// >>> bench/test_audio_amp_control_status_regs.sv
// self-checking bench for the audio amplifier control and status registers
`timescale 1ns/1ps
`default_nettype none
module test_audio_amp_control_status_regs;
	import aacsr_pkg::*;
	localparam logic [6:0] ID = 7'h2A; // arbitrary value
	localparam logic [7:0] RV [0:6] = '{8'h6C, {1'b0, ID}, 8'h00, 8'hA0, 8'h05, 8'h40, 8'h00}; // reset values
	localparam logic [7:0] WM [0:6] = '{8'h00, 8'h00, 8'hFB, 8'hA3, 8'h0F, 8'h40, 8'h03}; // writable bits
	localparam int         CH [0:6] = '{4, 4, 8, 6, 6, 16, 11};          // master half periods
	localparam int         CN [0:6] = '{64, 128, 192, 384, 512, 256, 512}; // ratios, legal with rate
	localparam logic [7:0] FB [0:2] = '{8'h40, 8'h02, 8'h01};             // fault flag per input
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pll_fail, power_fault, overtemp_warn, jump;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, d, lfsr;
	logic        pready, pslverr, er, mclk, sclk, lrclk, dcb, hun, shd;
	logic [1:0]  dem, smu;
	logic [3:0]  fmt;
	aacsr_apb_t  ph;
	logic [15:0] hm, rt, bt;
	logic [7:0]  sh [0:6]; // shadow of the registers
	int          err_total, samples_checked, cur_p, i, n, k;
	// 100 MHz clock
	always #5 pclk = ~pclk;
	aacsr_top #(.ID_CODE(ID)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.mclk_in(mclk), .sclk_in(sclk), .lrclk_in(lrclk), .pll_fail(pll_fail), .power_fault(power_fault),
		.overtemp_warn(overtemp_warn), .dc_block_en(dcb), .hard_unmute(hun), .deemph_sel(dem),
		.serial_format(fmt), .all_shutdown(shd), .apb_phase(ph), .soft_mute(smu));
	aacsr_clk_src src (.pclk(pclk), .presetn(presetn), .half_mc(hm), .ratio(rt), .bits(bt), .jump(jump),
		.mclk(mclk), .sclk(sclk), .lrclk(lrclk));
	// step of the stimulus generator
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// expected clock status from frame length and master clocks per frame
	function automatic logic [7:0] st_exp(input int p, input int m);
		logic [2:0] r;
		logic [2:0] q;
		r = p > 10526 ? 3'b110 : p > 7246 ? 3'b111 : p > 5263 ? 3'b100 : p > 3571 ? 3'b101 : p > 2631 ? 3'b000 : 3'b011;
		q = m < 96 ? 3'b000 : m < 160 ? 3'b001 : m < 224 ? 3'b010 : m < 320 ? 3'b011 : m < 448 ? 3'b100 : 3'b101;
		return {r, q, 2'b00};
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			err_total++;
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one transfer; the request is held until pready is seen at an edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] dw);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		if (k < 20) chk("apb phase", 32'h1, {31'h0, ph});
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			err_total++;
			results();
		end
	endtask
	task automatic rdc(input string nm, input int ix, input logic [7:0] ex);
		apb({3'h0, ix[2:0], 2'b00}, 1'b0, 32'h0);
		chk(nm, {24'h0, ex}, rd);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask
	// control outputs against the shadow, after the write has landed
	task automatic outc();
		@(negedge pclk);
		chk("outputs", {21'h0, sh[3][7], sh[3][5], sh[3][1:0], sh[4][3:0], sh[5][6], sh[6][1:0]},
			{21'h0, dcb, hun, dem, fmt, shd, smu});
	endtask
	task automatic wsh(input int ix, input logic [31:0] dw);
		apb({3'h0, ix[2:0], 2'b00}, 1'b1, dw);
		if (ix > 2 && ix < 7) sh[ix] = dw[7:0] & WM[ix];
		outc();
	endtask
	task automatic errc(input string nm, input logic [7:0] m, input logic [7:0] ex);
		apb(8'h08, 1'b0, 32'h0);
		chk(nm, {24'h0, ex}, {24'h0, rd[7:0] & m});
	endtask
	// new source settings, then wait out the old frame and one new one
	task automatic setclk(input int h, input int m, input int s);
		@(posedge pclk);
		hm <= 16'(h);
		rt <= 16'(m);
		bt <= 16'(s);
		repeat (cur_p + 2 * m * h + 16) @(posedge pclk);
		cur_p = 2 * m * h;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, pll_fail, power_fault, overtemp_warn, jump} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		hm = 16'h0004;
		rt = 16'h0100;
		bt = 16'h0040;
		lfsr = 32'h6EEF2A03;
		err_total = 0;
		samples_checked = 0;
		cur_p = 2048;
		for (i = 0; i < 7; i++) sh[i] = RV[i];
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		outc();
		for (i = 0; i < 7; i++) rdc("reset value", i, RV[i]);
		// unmapped and misaligned places answer with an error
		apb(8'h1C, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		apb(8'h0D, 1'b1, 32'hFF);
		chk("misaligned error", 32'h1, {31'h0, er});
		for (i = 0; i < 2; i++) begin
			wsh(i, 32'hFFFFFFFF);
			rdc("read only", i, RV[i]);
		end
		for (i = 0; i < 9; i++) begin
			wsh(4, i);
			rdc("format", 4, sh[4]);
		end
		for (i = 0; i < 4; i++) if (i != 1) wsh(3, 32'h20 | i);
		wsh(6, 32'hFF);
		wsh(5, 32'h00);
		// random traffic over every place except the error flags
		for (n = 0; n < 40; n++) begin
			lfsr = nxt(lfsr);
			d = nxt(lfsr);
			i = lfsr[2:0];
			if (i == 2) continue;
			if (i == 3 && d[1:0] == 2'b01) d[1] = 1'b1;
			if (i == 4 && d[3:0] > 4'h8) d[3] = 1'b0;
			wsh(i, d);
			if (i == 7) chk("unmapped error", 32'h1, {31'h0, er});
			else rdc("register", i, sh[i]);
		end
		for (i = 0; i < 7; i++) begin
			setclk(CH[i], CN[i], 64);
			rdc("clock status", 0, st_exp(2 * CN[i] * CH[i], CN[i]));
		end
		setclk(4, 128, 64);
		wsh(2, 32'h0);
		repeat (1100) @(posedge pclk);
		rdc("errors after clear", 2, 8'h00);
		setclk(4, 128, 32);
		errc("bit clock error", 8'hB0, 8'h20);
		wsh(2, 32'h0);
		setclk(8, 64, 32);
		errc("master clock error", 8'hB0, 8'h80);
		wsh(2, 32'h0);
		setclk(4, 64, 32);
		errc("frame clock error", 8'hB0, 8'h10);
		wsh(2, 32'h0);
		for (k = 0; k < 600; k++) begin
			@(posedge pclk);
			if (lrclk === 1'b0) break;
		end
		if (k == 600) begin
			err_total++;
			results();
		end
		jump <= 1'b1;
		@(posedge pclk);
		jump <= 1'b0;
		repeat (1040) @(posedge pclk);
		errc("frame slip", 8'h08, 8'h08);
		for (i = 0; i < 3; i++) begin
			wsh(2, 32'h0);
			@(posedge pclk);
			{pll_fail, power_fault, overtemp_warn} <= 3'b100 >> i;
			@(posedge pclk);
			{pll_fail, power_fault, overtemp_warn} <= 3'b000;
			repeat (4) @(posedge pclk);
			errc("fault flag", 8'h43, FB[i]);
			wsh(2, 32'hFF);
			errc("fault kept", 8'h43, FB[i]);
			wsh(2, 32'h0);
			errc("fault cleared", 8'h43, 8'h00);
		end
		results();
	end
endmodule
`default_nettype wire
